// ===== rtl/ncp_map.svh
// Register indexes, field positions and reset values of the preset and binding bank.
// Byte address of a register is four times its index.
`ifndef NCP_MAP_SVH
`define NCP_MAP_SVH
`define NCP_IDX_MODE        12'h214
`define NCP_IDX_SEL         12'h215
`define NCP_IDX_BIND        12'h216
`define NCP_IDX_RDIV_HI     12'h217
`define NCP_IDX_RDIV_LO     12'h218
`define NCP_IDX_FREQ_BASE   12'h300
`define NCP_IDX_PHASE_BASE  12'h310
`define NCP_RST_MODE        8'h00
`define NCP_RST_SEL         8'h00
`define NCP_RST_BIND        8'h02
`define NCP_RST_RDIV        16'h0000
`define NCP_RST_FREQ        32'hC0000000
`define NCP_RST_PHASE       16'h0000
`define NCP_SEL_A_LSB       0
`define NCP_SEL_B_LSB       2
`define NCP_BIND_A_BIT      0
`define NCP_BIND_B_BIT      1
`define NCP_MODE_REG_SEL    2'h0
`define NCP_MODE_PINS_AB    2'h1
`define NCP_MODE_PINS_A     2'h2
`define NCP_RESP_OKAY       2'h0
`define NCP_RESP_SLVERR     2'h2
`define NCP_SMP_W           12
`endif

// ===== rtl/ncp_pkg.sv
// Types shared by the preset and binding bank.
// Assumes ncp_map.svh is on the include path.
`include "ncp_map.svh"
package ncp_pkg;
  typedef logic [31:0] ncp_freq_t;
  typedef logic [15:0] ncp_phase_t;
  typedef logic [`NCP_SMP_W-1:0] ncp_sample_t;

  typedef struct packed {
    logic [1:0]            pin_a_s1;
    logic [1:0]            pin_a_s2;
    logic [1:0]            pin_b_s1;
    logic [1:0]            pin_b_s2;
    logic [7:0]            mode;
    logic [7:0]            sel;
    logic [7:0]            binding;
    logic [15:0]           rdiv;
    ncp_freq_t  [1:0][3:0] freq;
    ncp_phase_t [1:0][3:0] phase;
    logic                  aw_rdy;
    logic                  aw_hold;
    logic [11:0]           aw_idx;
    logic                  w_rdy;
    logic                  w_hold;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  ar_rdy;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    ncp_freq_t             act_freq_a;
    ncp_phase_t            act_phase_a;
    ncp_freq_t             act_freq_b;
    ncp_phase_t            act_phase_b;
    logic [15:0]           rdiv_out;
    ncp_sample_t           dig_a_data;
    ncp_sample_t           dig_b_data;
    logic                  bind_a_out;
    logic                  bind_b_out;
    logic                  pd_dig_a;
    logic                  pd_dig_b;
  } ncp_state_t;
endpackage

// ===== rtl/ncp_bank.sv
// Oscillator preset selection and digital channel binding bank, AXI4-Lite slave.
// Assumes power-down controls and converter samples come from logic on core_clk_i;
// preset select pins are asynchronous and are synchronised here.
// Behaviour
// - Each down-converter uses one of four frequency/phase presets per channel.
// - Mode 0: both down-converters take presets from the select register fields.
// - Mode 1: A uses A pins, B uses B pins.
// - Mode 2: both use A pins; mode 3 reserved, software must not write it.
// - Select bits 3-2 choose B's preset in mode 0 and reserved mode 3 only.
// - Select bits 1-0 choose A's preset in mode 0 and reserved mode 3 only.
// - Binding bit 1 routes converter A (clear) or B (set) to digital B; resets set.
// - Binding bit 0 routes converter A (clear) or B (set) to digital A; resets clear.
// - Digital channel and its link power down with their bound converter channel.
// - Rational divisor is 16-bit RW over two addresses, high first, reset zero.
// - Rational divisor accompanies every active preset to cancel frequency error.
`timescale 1ns/100ps
`include "ncp_map.svh"
module ncp_bank
  import ncp_pkg::*;
(
  input  wire logic               core_clk_i,
  input  wire logic               reset_i,
  input  wire logic [31:0]        s_axi_awaddr_i,
  input  wire logic               s_axi_awvalid_i,
  output logic                    s_axi_awready_o,
  input  wire logic [31:0]        s_axi_wdata_i,
  input  wire logic [3:0]         s_axi_wstrb_i,
  input  wire logic               s_axi_wvalid_i,
  output logic                    s_axi_wready_o,
  output logic [1:0]              s_axi_bresp_o,
  output logic                    s_axi_bvalid_o,
  input  wire logic               s_axi_bready_i,
  input  wire logic [31:0]        s_axi_araddr_i,
  input  wire logic               s_axi_arvalid_i,
  output logic                    s_axi_arready_o,
  output logic [31:0]             s_axi_rdata_o,
  output logic [1:0]              s_axi_rresp_o,
  output logic                    s_axi_rvalid_o,
  input  wire logic               s_axi_rready_i,
  input  wire logic [1:0]         preset_pins_a_i,
  input  wire logic [1:0]         preset_pins_b_i,
  input  wire logic               powerdown_chan_a_i,
  input  wire logic               powerdown_chan_b_i,
  input  wire ncp_pkg::ncp_sample_t adc_a_data_i,
  input  wire ncp_pkg::ncp_sample_t adc_b_data_i,
  output ncp_pkg::ncp_freq_t      act_freq_a_o,
  output ncp_pkg::ncp_phase_t     act_phase_a_o,
  output ncp_pkg::ncp_freq_t      act_freq_b_o,
  output ncp_pkg::ncp_phase_t     act_phase_b_o,
  output logic [15:0]             rational_divisor_o,
  output ncp_pkg::ncp_sample_t    dig_a_data_o,
  output ncp_pkg::ncp_sample_t    dig_b_data_o,
  output logic                    binding_sel_a_o,
  output logic                    binding_sel_b_o,
  output logic                    powerdown_dig_a_o,
  output logic                    powerdown_dig_b_o
);
  import ncp_pkg::*;

  ncp_state_t r;
  ncp_state_t next_r;

  function automatic logic [31:0] read_reg(input ncp_state_t s, input logic [11:0] idx, output logic hit);
    logic [31:0] d;
    d   = 32'h00000000;
    hit = 1'b1;
    if (idx == `NCP_IDX_MODE) begin
      d = {24'h000000, s.mode};
    end else if (idx == `NCP_IDX_SEL) begin
      d = {24'h000000, s.sel};
    end else if (idx == `NCP_IDX_BIND) begin
      d = {24'h000000, s.binding};
    end else if (idx == `NCP_IDX_RDIV_HI) begin
      d = {24'h000000, s.rdiv[15:8]};
    end else if (idx == `NCP_IDX_RDIV_LO) begin
      d = {24'h000000, s.rdiv[7:0]};
    end else if (idx[11:3] == `NCP_IDX_FREQ_BASE >> 3) begin
      d = s.freq[idx[2]][idx[1:0]];
    end else if (idx[11:3] == `NCP_IDX_PHASE_BASE >> 3) begin
      d = {16'h0000, s.phase[idx[2]][idx[1:0]]};
    end else begin
      hit = 1'b0;
    end
    return d;
  endfunction

  function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] d, input logic [3:0] st);
    return st[0] ? d[7:0] : old;
  endfunction

  always_comb begin
    logic [1:0]  pick_a;
    logic [1:0]  pick_b;
    logic        hit;
    logic [31:0] rd;
    logic [11:0] idx;
    logic [7:0]  hi;
    pick_a = 2'h0;
    pick_b = 2'h0;
    hit    = 1'b0;
    rd     = 32'h00000000;
    idx    = 12'h000;
    hi     = 8'h00;
    next_r = r;

    // Pin synchronisers
    next_r.pin_a_s1 = preset_pins_a_i;
    next_r.pin_a_s2 = r.pin_a_s1;
    next_r.pin_b_s1 = preset_pins_b_i;
    next_r.pin_b_s2 = r.pin_b_s1;

    // Write address and data taken independently
    if (s_axi_awvalid_i && r.aw_rdy) begin
      next_r.aw_hold = 1'b1;
      next_r.aw_idx  = s_axi_awaddr_i[13:2];
    end
    if (s_axi_wvalid_i && r.w_rdy) begin
      next_r.w_hold = 1'b1;
      next_r.wdata  = s_axi_wdata_i;
      next_r.wstrb  = s_axi_wstrb_i;
    end
    if (r.bvalid && s_axi_bready_i) begin
      next_r.bvalid = 1'b0;
    end
    if (r.aw_hold && r.w_hold && !r.bvalid) begin
      idx            = r.aw_idx;
      next_r.aw_hold = 1'b0;
      next_r.w_hold  = 1'b0;
      next_r.bvalid  = 1'b1;
      next_r.bresp   = `NCP_RESP_OKAY;
      if (idx == `NCP_IDX_MODE) begin
        next_r.mode = merge8(r.mode, r.wdata, r.wstrb);
      end else if (idx == `NCP_IDX_SEL) begin
        next_r.sel = merge8(r.sel, r.wdata, r.wstrb);
      end else if (idx == `NCP_IDX_BIND) begin
        next_r.binding = merge8(r.binding, r.wdata, r.wstrb);
      end else if (idx == `NCP_IDX_RDIV_HI) begin
        hi = merge8(r.rdiv[15:8], r.wdata, r.wstrb);
        next_r.rdiv[15:8] = hi;
      end else if (idx == `NCP_IDX_RDIV_LO) begin
        next_r.rdiv[7:0] = merge8(r.rdiv[7:0], r.wdata, r.wstrb);
      end else if (idx[11:3] == `NCP_IDX_FREQ_BASE >> 3) begin
        for (int i = 0; i < 4; i++) begin
          if (r.wstrb[i]) begin
            next_r.freq[idx[2]][idx[1:0]][i*8 +: 8] = r.wdata[i*8 +: 8];
          end
        end
      end else if (idx[11:3] == `NCP_IDX_PHASE_BASE >> 3) begin
        for (int i = 0; i < 2; i++) begin
          if (r.wstrb[i]) begin
            next_r.phase[idx[2]][idx[1:0]][i*8 +: 8] = r.wdata[i*8 +: 8];
          end
        end
      end else begin
        next_r.bresp = `NCP_RESP_SLVERR;
      end
    end
    next_r.aw_rdy = !next_r.aw_hold;
    next_r.w_rdy  = !next_r.w_hold;

    // Read channel
    if (r.rvalid && s_axi_rready_i) begin
      next_r.rvalid = 1'b0;
      next_r.ar_rdy = 1'b1;
    end
    if (s_axi_arvalid_i && r.ar_rdy) begin
      rd            = read_reg(r, s_axi_araddr_i[13:2], hit);
      next_r.ar_rdy = 1'b0;
      next_r.rvalid = 1'b1;
      next_r.rdata  = rd;
      next_r.rresp  = hit ? `NCP_RESP_OKAY : `NCP_RESP_SLVERR;
    end

    // Preset source selection
    unique case (r.mode[1:0])
      `NCP_MODE_PINS_AB: begin
        pick_a = r.pin_a_s2;
        pick_b = r.pin_b_s2;
      end
      `NCP_MODE_PINS_A: begin
        pick_a = r.pin_a_s2;
        pick_b = r.pin_a_s2;
      end
      default: begin
        // Reserved mode falls back to register selection
        pick_a = r.sel[`NCP_SEL_A_LSB +: 2];
        pick_b = r.sel[`NCP_SEL_B_LSB +: 2];
      end
    endcase
    next_r.act_freq_a  = r.freq[0][pick_a];
    next_r.act_phase_a = r.phase[0][pick_a];
    next_r.act_freq_b  = r.freq[1][pick_b];
    next_r.act_phase_b = r.phase[1][pick_b];
    next_r.rdiv_out    = r.rdiv;

    // Channel binding and power-down
    next_r.bind_a_out = r.binding[`NCP_BIND_A_BIT];
    next_r.bind_b_out = r.binding[`NCP_BIND_B_BIT];
    next_r.dig_a_data = r.binding[`NCP_BIND_A_BIT] ? adc_b_data_i : adc_a_data_i;
    next_r.dig_b_data = r.binding[`NCP_BIND_B_BIT] ? adc_b_data_i : adc_a_data_i;
    next_r.pd_dig_a   = r.binding[`NCP_BIND_A_BIT] ? powerdown_chan_b_i : powerdown_chan_a_i;
    next_r.pd_dig_b   = r.binding[`NCP_BIND_B_BIT] ? powerdown_chan_b_i : powerdown_chan_a_i;
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      r             <= '0;
      r.mode        <= `NCP_RST_MODE;
      r.sel         <= `NCP_RST_SEL;
      r.binding     <= `NCP_RST_BIND;
      r.rdiv        <= `NCP_RST_RDIV;
      r.freq        <= {8{`NCP_RST_FREQ}};
      r.phase       <= {8{`NCP_RST_PHASE}};
      r.aw_rdy      <= 1'b1;
      r.w_rdy       <= 1'b1;
      r.ar_rdy      <= 1'b1;
      r.act_freq_a  <= `NCP_RST_FREQ;
      r.act_freq_b  <= `NCP_RST_FREQ;
      r.bind_b_out  <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign s_axi_awready_o    = r.aw_rdy;
  assign s_axi_wready_o     = r.w_rdy;
  assign s_axi_bvalid_o     = r.bvalid;
  assign s_axi_bresp_o      = r.bresp;
  assign s_axi_arready_o    = r.ar_rdy;
  assign s_axi_rvalid_o     = r.rvalid;
  assign s_axi_rdata_o      = r.rdata;
  assign s_axi_rresp_o      = r.rresp;
  assign act_freq_a_o       = r.act_freq_a;
  assign act_phase_a_o      = r.act_phase_a;
  assign act_freq_b_o       = r.act_freq_b;
  assign act_phase_b_o      = r.act_phase_b;
  assign rational_divisor_o = r.rdiv_out;
  assign dig_a_data_o       = r.dig_a_data;
  assign dig_b_data_o       = r.dig_b_data;
  assign binding_sel_a_o    = r.bind_a_out;
  assign binding_sel_b_o    = r.bind_b_out;
  assign powerdown_dig_a_o  = r.pd_dig_a;
  assign powerdown_dig_b_o  = r.pd_dig_b;
endmodule // ncp_bank

// ===== dv/ncp_bank_asserts.sv
// Port checker for the preset and binding bank.
// Bound onto ncp_bank from the bench top file; one clock domain.
`timescale 1ns/100ps
module ncp_bank_asserts (
  input wire logic                 core_clk_i,
  input wire logic                 reset_i,
  input wire logic                 s_axi_awvalid_i,
  input wire logic                 s_axi_awready_o,
  input wire logic                 s_axi_wvalid_i,
  input wire logic                 s_axi_wready_o,
  input wire logic                 s_axi_bvalid_o,
  input wire logic                 s_axi_bready_i,
  input wire logic                 s_axi_arvalid_i,
  input wire logic                 s_axi_arready_o,
  input wire logic                 s_axi_rvalid_o,
  input wire logic                 s_axi_rready_i,
  input wire logic [31:0]          s_axi_rdata_o,
  input wire logic [1:0]           s_axi_rresp_o,
  input wire logic                 powerdown_chan_a_i,
  input wire logic                 powerdown_chan_b_i,
  input wire ncp_pkg::ncp_sample_t adc_a_data_i,
  input wire ncp_pkg::ncp_sample_t adc_b_data_i,
  input wire ncp_pkg::ncp_sample_t dig_a_data_o,
  input wire ncp_pkg::ncp_sample_t dig_b_data_o,
  input wire logic                 binding_sel_a_o,
  input wire logic                 binding_sel_b_o,
  input wire logic                 powerdown_dig_a_o
);
  import ncp_pkg::*;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  sequence wr_both;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence wr_resp;
    !s_axi_awready_o ##1 s_axi_bvalid_o;
  endsequence
  wr_resp_a: assert property (wr_both |=> wr_resp) else $error("write response late");
  rd_resp_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o)
    else $error("read response late");
  bresp_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o) else $error("bvalid dropped");
  rdata_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data not held");
  rresp_code_a: assert property (s_axi_rvalid_o |-> !s_axi_rresp_o[0]) else $error("bad read response code");
  bind_reset_a: assert property ($fell(reset_i) |-> binding_sel_b_o && !binding_sel_a_o)
    else $error("binding reset value wrong");
  route_dig_a_a: assert property (!$past(reset_i) && $stable(binding_sel_a_o) |->
    dig_a_data_o == (binding_sel_a_o ? $past(adc_b_data_i) : $past(adc_a_data_i))) else $error("digital A route");
  route_dig_b_a: assert property (!$past(reset_i) && $stable(binding_sel_b_o) |->
    dig_b_data_o == (binding_sel_b_o ? $past(adc_b_data_i) : $past(adc_a_data_i))) else $error("digital B route");
  pd_follow_a: assert property (!$past(reset_i) && $stable(binding_sel_a_o) |->
    powerdown_dig_a_o == (binding_sel_a_o ? $past(powerdown_chan_b_i) : $past(powerdown_chan_a_i)))
    else $error("digital A power-down");
endmodule // ncp_bank_asserts

// ===== dv/ncp_far_end.sv
// Far side: preset select pin driver and converter sample source.
// Assumes the bench names the wanted pin values and enables random power-down.
`timescale 1ns/100ps
module ncp_far_end (
  input wire logic             core_clk_i,
  input wire logic [1:0]       want_a_i,
  input wire logic [1:0]       want_b_i,
  input wire logic             pd_en_i,
  output logic [1:0]           pins_a_o,
  output logic [1:0]           pins_b_o,
  output logic                 pd_a_o,
  output logic                 pd_b_o,
  output ncp_pkg::ncp_sample_t adc_a_o,
  output ncp_pkg::ncp_sample_t adc_b_o
);
  import ncp_pkg::*;
  initial begin
    {pins_a_o, pins_b_o, pd_a_o, pd_b_o, adc_a_o, adc_b_o} = '0;
  end
  // Samples change every cycle; power-down is random only while pd_en_i is set
  always @(posedge core_clk_i) begin
    pins_a_o <= want_a_i;
    pins_b_o <= want_b_i;
    pd_a_o <= pd_en_i & 1'($urandom);
    pd_b_o <= pd_en_i & 1'($urandom);
    adc_a_o <= ncp_sample_t'($urandom);
    adc_b_o <= ncp_sample_t'($urandom);
  end
endmodule // ncp_far_end

// ===== dv/tb_ncp_bank.sv
// Bench for the preset and binding bank: register model compared over AXI4-Lite.
// Assumes ncp_bank, ncp_far_end and ncp_bank_asserts are compiled before it.
`timescale 1ns/100ps
module tb_ncp_bank;
  import ncp_pkg::*;
  logic core_clk_i = 1'b0, reset_i = 1'b1, pd_en = 1'b0;
  logic [31:0] s_axi_awaddr_i = 32'h0, s_axi_wdata_i = 32'h0, s_axi_araddr_i = 32'h0, s_axi_rdata_o, rd;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0, s_axi_arvalid_i = 1'b0;
  logic s_axi_rready_i = 1'b0, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [3:0] s_axi_wstrb_i = 4'hF;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rs, want_a = 2'h0, want_b = 2'h0, preset_pins_a_i, preset_pins_b_i;
  logic powerdown_chan_a_i, powerdown_chan_b_i, binding_sel_a_o, binding_sel_b_o, powerdown_dig_a_o, powerdown_dig_b_o;
  ncp_sample_t adc_a_data_i, adc_b_data_i, dig_a_data_o, dig_b_data_o;
  ncp_freq_t act_freq_a_o, act_freq_b_o;
  ncp_phase_t act_phase_a_o, act_phase_b_o;
  logic [15:0] rational_divisor_o;
  logic [31:0] mf[8], mp[8];
  int err_count = 0, check_count = 0, mode = 0, sel = 0, bnd = 2, rdiv = 0;
  initial forever #20 core_clk_i = ~core_clk_i;
  ncp_bank dut (.core_clk_i, .reset_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
    .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
    .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
    .s_axi_rready_i, .preset_pins_a_i, .preset_pins_b_i, .powerdown_chan_a_i, .powerdown_chan_b_i, .adc_a_data_i,
    .adc_b_data_i, .act_freq_a_o, .act_phase_a_o, .act_freq_b_o, .act_phase_b_o, .rational_divisor_o,
    .dig_a_data_o, .dig_b_data_o, .binding_sel_a_o, .binding_sel_b_o, .powerdown_dig_a_o, .powerdown_dig_b_o);
  ncp_far_end u_far (.core_clk_i, .want_a_i(want_a), .want_b_i(want_b), .pd_en_i(pd_en), .pins_a_o(preset_pins_a_i),
    .pins_b_o(preset_pins_b_i), .pd_a_o(powerdown_chan_a_i), .pd_b_o(powerdown_chan_b_i), .adc_a_o(adc_a_data_i),
    .adc_b_o(adc_b_data_i));
  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input int i, input int d);
    int lag;
    lag = $urandom % 4;
    @(posedge core_clk_i);
    s_axi_awaddr_i <= {18'h0, i[11:0], 2'h0};
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= (lag == 0);
    // Late bready makes the response stand a few cycles
    do begin
      @(posedge core_clk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      if (lag > 0) lag--;
      if (lag == 0) s_axi_bready_i <= 1'b1;
    end while (s_axi_bvalid_o !== 1'b1 || s_axi_bready_i !== 1'b1);
    rs = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
  endtask
  task rd_reg(input int i);
    int lag;
    lag = $urandom % 4;
    @(posedge core_clk_i);
    s_axi_araddr_i <= {18'h0, i[11:0], 2'h0};
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= (lag == 0);
    do begin
      @(posedge core_clk_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      if (lag > 0) lag--;
      if (lag == 0) s_axi_rready_i <= 1'b1;
    end while (s_axi_rvalid_o !== 1'b1 || s_axi_rready_i !== 1'b1);
    rd = s_axi_rdata_o;
    rs = s_axi_rresp_o;
    s_axi_rready_i <= 1'b0;
  endtask
  task chk_rd(input int i, input logic [31:0] e);
    rd_reg(i);
    chk(rd, e);
  endtask
  // Active preset number of one down-converter in the model
  function automatic int pidx(int ch);
    if (mode % 4 == 1) return ch ? int'(want_b) : int'(want_a);
    if (mode % 4 == 2) return int'(want_a);
    return ch ? (sel >> 2) % 4 : sel % 4;
  endfunction
  task chk_act;
    repeat (5) @(posedge core_clk_i);
    chk(act_freq_a_o, mf[pidx(0)]);
    chk(act_phase_a_o, mp[pidx(0)]);
    chk(act_freq_b_o, mf[4 + pidx(1)]);
    chk(act_phase_b_o, mp[4 + pidx(1)]);
  endtask
  initial begin
    int xa, xb, pa, pb;
    void'($urandom(32'h5a98e28e));
    foreach (mf[k]) {mf[k], mp[k]} = {32'hC0000000, 32'h0};
    repeat (12) @(posedge core_clk_i);
    reset_i <= 1'b0;
    chk_rd(12'h214, 0);
    chk_rd(12'h215, 0);
    chk_rd(12'h216, 2);
    chk_rd(12'h217, 0);
    chk_rd(12'h218, 0);
    chk(act_freq_a_o, mf[0]);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      mf[i] = $urandom;
      mp[i] = $urandom % 65536;
      wr(12'h300 + i, mf[i]);
      chk(rs, 2'h0);
      wr(12'h310 + i, mp[i]);
      chk_rd(12'h300 + i, mf[i]);
      chk_rd(12'h310 + i, mp[i]);
    end
    for (int i = 0; i < 16; i++) begin
      sel = ($urandom % 16) * 16 + i;
      wr(12'h215, sel);
      chk_rd(12'h215, sel);
      chk_act;
    end
    $display("register select test done");
    for (int m = 1; m < 3; m++) begin
      mode = m + 4 * ($urandom % 64);
      wr(12'h214, mode); // Reserved mode 3 never written
      chk_rd(12'h214, mode);
      for (int i = 0; i < 16; i++) begin
        want_a <= i[1:0];
        want_b <= i[3:2];
        chk_act;
      end
    end
    mode = 0;
    wr(12'h214, mode);
    $display("pin select test done");
    pd_en <= 1'b1;
    for (int b = 0; b < 4; b++) begin
      bnd = b + 4 * ($urandom % 64);
      wr(12'h216, bnd); // Each of the four routings in bits 1-0, bits 7-2 random
      chk_rd(12'h216, bnd);
      chk(binding_sel_a_o, b % 2);
      chk(binding_sel_b_o, b / 2);
      repeat (8) begin
        @(posedge core_clk_i);
        {xa, xb, pa, pb} = {32'(adc_a_data_i), 32'(adc_b_data_i), 32'(powerdown_chan_a_i), 32'(powerdown_chan_b_i)};
        @(posedge core_clk_i);
        chk(dig_a_data_o, b % 2 ? xb : xa);
        chk(dig_b_data_o, b / 2 ? xb : xa);
        chk(powerdown_dig_a_o, b % 2 ? pb : pa);
        chk(powerdown_dig_b_o, b / 2 ? pb : pa);
      end
    end
    $display("binding test done");
    rdiv = $urandom % 65536;
    wr(12'h217, rdiv / 256);
    wr(12'h218, rdiv % 256);
    chk_rd(12'h217, rdiv / 256);
    chk_rd(12'h218, rdiv % 256);
    chk(rational_divisor_o, rdiv);
    s_axi_wstrb_i <= 4'h0;
    wr(12'h217, 32'hFF);
    s_axi_wstrb_i <= 4'hF;
    chk_rd(12'h217, rdiv / 256);
    wr(12'h200, 32'hFF);
    chk(rs, 2'h2);
    chk_rd(12'h200, 0);
    chk(rs, 2'h2);
    $display("divisor and unmapped test done");
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge core_clk_i);
    err_count++;
    end_of_test;
  end
endmodule // tb_ncp_bank
bind ncp_bank ncp_bank_asserts u_chk (.core_clk_i, .reset_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i,
  .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o,
  .s_axi_rready_i, .s_axi_rdata_o, .s_axi_rresp_o, .powerdown_chan_a_i, .powerdown_chan_b_i, .adc_a_data_i,
  .adc_b_data_i, .dig_a_data_o, .dig_b_data_o, .binding_sel_a_o, .binding_sel_b_o, .powerdown_dig_a_o);
